/* File: pkg/smb_cfg.svh */
// Behaviour
// - Two-hand mute: once first sensor pair is active, released mutable hands keep output on.
// - Two-hand mute ends off when first pair stops or mute limit expires.
// - Releasing any non-mutable hand set during mute turns outputs off.
// - Bidirectional mute needs guard run, mute enable, sensors in sequence within 3 s.
// - During mute, a stop from the muted safeguard leaves outputs on.
// - With a mute limit configured, timer expiry during mute turns outputs off.
// - During mute, a stop from any non-muted safeguard turns outputs off.
// - Bidirectional muting also works with sensors activated in reverse order.
// - Unidirectional: pair one, guard stop, pair two, pair one off keeps output on.
// - Unidirectional wrong order never mutes; output drops when guard stops.
// - Mute on power-up starts a mute cycle if sensors active and guards run.
// - Guard stopped, one sensor active: lamp flashes, bypass starts override, output on.
// - Override ends off on mute limit, sensors inactive, or bypass switch released.
// - Bypass switch to run turns outputs on until bypass timer expires.
// - During bypass, any non-bypassed input in stop turns outputs off.
// - Off-delayed output stays on for the delay after input stop, then off.
// - Input back to run during off-delay abandons the pending turn-off unless latching is enabled.
// - Cancel-delay input during off-delay turns output off immediately.
// - Latched delayed output ignores latch reset during delay, turns off and stays off.
// - Enabling timer expiry turns output off until enabling device cycles stop-run.
// - System reset with enabling device in stop returns control to plain inputs.
// - Jog secondary output on only while enabling device and jog both run.
`ifndef SMB_CFG_SVH
`define SMB_CFG_SVH

// Timing
`define SMB_CLK_HZ 32'h05F5_E100
`define SMB_SEQ_WIN_S 32'h0000_0003
`define SMB_LAMP_HALF_MS 32'h0000_00FA
`define SMB_MS_PER_S 32'h0000_03E8

// Register byte addresses
`define SMB_A_CTRL 12'h000
`define SMB_A_MUTE_T 12'h004
`define SMB_A_BYP_T 12'h008
`define SMB_A_DLY_T 12'h00C
`define SMB_A_EN_T 12'h010
`define SMB_A_STAT 12'h014

// Reset values
`define SMB_CTRL_RST 10'h000
`define SMB_TIME_RST 32'h05F5_E100

// Timer slots
`define SMB_NUM_TMR 5
`define SMB_NUM_TREG 4
`define SMB_T_MUTE 0
`define SMB_T_BYP 1
`define SMB_T_DLY 2
`define SMB_T_EN 3
`define SMB_T_SEQ 4

// Power-up settle
`define SMB_PU_LAST 2'h2
`define SMB_PU_LIVE 2'h3

`endif

/* File: pkg/smb_pkg.sv */
package smb_pkg;

   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_ARM = 5'h02,
      ST_MUTE = 5'h04,
      ST_OVRD = 5'h08,
      ST_BYP = 5'h10
   } smb_state_t;

   // Field inputs, high = run / active / pressed
   typedef struct packed
   {
      logic hand;
      logic hand_nm;
      logic first_mute_sensor_pair;
      logic msp2;
      logic guard;
      logic nm_guard;
      logic mute_en;
      logic bypass;
      logic cancel;
      logic latch_rst;
      logic en_dev;
      logic jog;
      logic sys_btn;
   } smb_pins_t;

   typedef struct packed
   {
      logic two_hand;
      logic bidir;
      logic mute_pu;
      logic lim_en;
      logic use_men;
      logic mdo_en;
      logic latch_en;
      logic jog_en;
      logic dly_en;
      logic en_fn;
   } smb_ctrl_t;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } smb_apb_req_t;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } smb_apb_rsp_t;

endpackage

/* File: verilog/smb_timer.sv */
`timescale 1ns/1ns
module smb_timer
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Control
   input wire logic i_start,
   input wire logic i_run,
   input wire logic [31:0] i_load,
   // Status
   output logic o_done
);
   logic [31:0] cnt;
   logic active;

   // Dropping i_run abandons the count, so a stale expiry never fires later
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         cnt <= 32'h0;
         active <= 1'b0;
         o_done <= 1'b0;
      end
      else if (i_start)
      begin
         cnt <= i_load;
         active <= 1'b1;
         o_done <= 1'b0;
      end
      else if (!i_run)
      begin
         active <= 1'b0;
         o_done <= 1'b0;
      end
      else if (active && cnt == 32'h0)
      begin
         active <= 1'b0;
         o_done <= 1'b1;
      end
      // Done is a one-cycle pulse, so a finished count never reads as a fresh expiry
      else
      begin
         o_done <= 1'b0;
         if (active)
            cnt <= cnt - 32'h1;
      end
   end
endmodule

/* File: verilog/smb_top.sv */
`timescale 1ns/1ns
`include "smb_cfg.svh"
module smb_top
#(
   parameter logic [31:0] SEQ_CYCLES = `SMB_SEQ_WIN_S * `SMB_CLK_HZ,
   parameter logic [31:0] LAMP_CYCLES = `SMB_LAMP_HALF_MS * (`SMB_CLK_HZ / `SMB_MS_PER_S)
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // APB slave
   input wire smb_pkg::smb_apb_req_t i_apb,
   output smb_pkg::smb_apb_rsp_t o_apb,
   // Field inputs, asynchronous
   input wire smb_pkg::smb_pins_t i_pins,
   // Safety outputs and lamp
   output logic o_so1,
   output logic o_so2,
   output logic o_mute_lamp
);
   smb_pkg::smb_pins_t meta;
   smb_pkg::smb_pins_t s;
   smb_pkg::smb_pins_t p;
   smb_pkg::smb_ctrl_t ctrl;
   smb_pkg::smb_state_t st;
   smb_pkg::smb_state_t next_st;
   logic [31:0] treg [0:`SMB_NUM_TREG-1];
   logic [31:0] tload [0:`SMB_NUM_TMR-1];
   logic [`SMB_NUM_TMR-1:0] tstart;
   logic [`SMB_NUM_TMR-1:0] trun;
   logic [`SMB_NUM_TMR-1:0] tdone;
   logic [1:0] pu_cnt;
   logic pu_live;
   logic dir;
   logic trip;
   logic th_arm;
   logic th_run;
   logic en_mode;
   logic en_lock;
   logic dly;
   logic lat_off;
   logic raw_in;
   logic raw;
   logic mute_ok;
   logic mute_end;
   logic ovrd_end;
   logic lrst;
   logic flash;
   logic blink;
   logic [31:0] lamp_cnt;
   logic acc;

   function automatic logic rise(input logic cur, input logic prev);
      rise = cur && !prev;
   endfunction

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a == `SMB_A_CTRL) || (a == `SMB_A_MUTE_T) || (a == `SMB_A_BYP_T) ||
                (a == `SMB_A_DLY_T) || (a == `SMB_A_EN_T) || (a == `SMB_A_STAT);
   endfunction

   // Two-stage synchroniser on every field input
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         meta <= '0;
         s <= '0;
      end
      else
      begin
         meta <= i_pins;
         s <= meta;
      end
   end

   // Previous values read as all-active until settled, so held inputs never look like edges
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !pu_live)
         p <= '1;
      else
         p <= s;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         pu_cnt <= 2'h0;
      else if (!pu_live)
         pu_cnt <= pu_cnt + 2'h1;
   end

   assign pu_live = (pu_cnt == `SMB_PU_LIVE);
   assign mute_ok = s.guard && (s.mute_en || !ctrl.use_men);
   assign lrst = rise(s.latch_rst, p.latch_rst);

   always_comb
   begin
      if (ctrl.two_hand)
         mute_end = !s.first_mute_sensor_pair || (ctrl.lim_en && tdone[`SMB_T_MUTE]) || !s.hand_nm || !s.nm_guard;
      else
         mute_end = (!s.first_mute_sensor_pair && !s.msp2) || (ctrl.lim_en && tdone[`SMB_T_MUTE]) || !s.nm_guard;
      ovrd_end = (ctrl.lim_en && tdone[`SMB_T_MUTE]) || (!s.first_mute_sensor_pair && !s.msp2) || !s.bypass;
   end

   always_comb
   begin
      next_st = st;
      case (st)
         smb_pkg::ST_IDLE:
         begin
            if (!pu_live)
            begin
               if (pu_cnt == `SMB_PU_LAST && ctrl.mute_pu && !ctrl.two_hand && mute_ok &&
                   s.nm_guard && (s.first_mute_sensor_pair || s.msp2))
                  next_st = smb_pkg::ST_MUTE;
            end
            else if (ctrl.mdo_en && !s.guard && (s.first_mute_sensor_pair || s.msp2) && rise(s.bypass, p.bypass))
               next_st = smb_pkg::ST_OVRD;
            else if (!ctrl.mdo_en && rise(s.bypass, p.bypass))
               next_st = smb_pkg::ST_BYP;
            else if (ctrl.two_hand && th_run && s.first_mute_sensor_pair)
               next_st = smb_pkg::ST_MUTE;
            else if (!ctrl.two_hand && mute_ok && !trip)
            begin
               if (rise(s.first_mute_sensor_pair, p.first_mute_sensor_pair) && !s.msp2)
                  next_st = ctrl.bidir ? smb_pkg::ST_ARM : smb_pkg::ST_MUTE;
               else if (ctrl.bidir && rise(s.msp2, p.msp2) && !s.first_mute_sensor_pair)
                  next_st = smb_pkg::ST_ARM;
            end
         end
         smb_pkg::ST_ARM:
         begin
            if (!mute_ok || tdone[`SMB_T_SEQ])
               next_st = smb_pkg::ST_IDLE;
            else if (dir ? s.first_mute_sensor_pair : s.msp2)
               next_st = smb_pkg::ST_MUTE;
            else if (!s.first_mute_sensor_pair && !s.msp2)
               next_st = smb_pkg::ST_IDLE;
         end
         smb_pkg::ST_MUTE:
         begin
            if (mute_end)
               next_st = smb_pkg::ST_IDLE;
         end
         smb_pkg::ST_OVRD:
         begin
            if (ovrd_end)
               next_st = smb_pkg::ST_IDLE;
         end
         smb_pkg::ST_BYP:
         begin
            if (tdone[`SMB_T_BYP] || !s.bypass)
               next_st = smb_pkg::ST_IDLE;
         end
         default:
            next_st = smb_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         st <= smb_pkg::ST_IDLE;
      else
         st <= next_st;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         dir <= 1'b0;
      else if (st == smb_pkg::ST_IDLE && next_st == smb_pkg::ST_ARM)
         dir <= s.msp2;
   end

   // A mute cut short by its limit keeps the output off until the sensors clear
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         trip <= 1'b0;
      else if (st == smb_pkg::ST_MUTE && next_st == smb_pkg::ST_IDLE && ctrl.lim_en && tdone[`SMB_T_MUTE])
         trip <= 1'b1;
      else if (!s.first_mute_sensor_pair && !s.msp2)
         trip <= 1'b0;
   end

   // Two-hand needs a full release before each cycle; after reset the cleared synchroniser arms it without one
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         th_arm <= 1'b0;
      else if (!s.hand && !s.hand_nm)
         th_arm <= 1'b1;
      else if (th_run)
         th_arm <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         th_run <= 1'b0;
      else if (st == smb_pkg::ST_MUTE && next_st != smb_pkg::ST_MUTE)
         th_run <= 1'b0;
      else if (st != smb_pkg::ST_MUTE && !(s.hand && s.hand_nm && s.guard))
         th_run <= 1'b0;
      else if (th_arm && s.hand && s.hand_nm && s.guard)
         th_run <= 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !ctrl.en_fn)
      begin
         en_mode <= 1'b0;
         en_lock <= 1'b0;
      end
      else if (rise(s.sys_btn, p.sys_btn) && !s.en_dev)
      begin
         en_mode <= 1'b0;
         en_lock <= 1'b0;
      end
      else if (rise(s.en_dev, p.en_dev))
      begin
         en_mode <= 1'b1;
         en_lock <= 1'b0;
      end
      else if (en_mode && s.en_dev && tdone[`SMB_T_EN])
         en_lock <= 1'b1;
   end

   always_comb
   begin
      case (st)
         smb_pkg::ST_MUTE:
            raw_in = ctrl.two_hand ? s.hand_nm : 1'b1;
         smb_pkg::ST_OVRD, smb_pkg::ST_BYP:
            raw_in = 1'b1;
         default:
            raw_in = ctrl.two_hand ? th_run : (s.guard && !trip);
      endcase
      if (ctrl.en_fn && en_mode)
         raw = s.en_dev && !en_lock && s.nm_guard;
      else
         raw = raw_in && s.nm_guard;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_so1 <= 1'b0;
         dly <= 1'b0;
         lat_off <= 1'b1;
      end
      else if (dly)
      begin
         if (s.cancel || tdone[`SMB_T_DLY])
         begin
            o_so1 <= 1'b0;
            dly <= 1'b0;
            lat_off <= 1'b1;
         end
         else if (raw && !ctrl.latch_en)
            dly <= 1'b0;
      end
      else if (o_so1)
      begin
         if (!raw && ctrl.dly_en)
            dly <= 1'b1;
         else if (!raw)
         begin
            o_so1 <= 1'b0;
            lat_off <= 1'b1;
         end
      end
      else if (raw && (!ctrl.latch_en || !lat_off))
         o_so1 <= 1'b1;
      else if (raw && lrst)
         lat_off <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_so2 <= 1'b0;
      else
         o_so2 <= ctrl.jog_en && s.en_dev && s.jog;
   end

   // lamp flashes while override is possible
   assign flash = (st == smb_pkg::ST_OVRD) ||
                  (ctrl.mdo_en && st == smb_pkg::ST_IDLE && !s.guard && (s.first_mute_sensor_pair || s.msp2));

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || !flash)
      begin
         lamp_cnt <= 32'h0;
         blink <= 1'b0;
      end
      else if (lamp_cnt == LAMP_CYCLES - 32'h1)
      begin
         lamp_cnt <= 32'h0;
         blink <= !blink;
      end
      else
         lamp_cnt <= lamp_cnt + 32'h1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_mute_lamp <= 1'b0;
      else
         o_mute_lamp <= (st == smb_pkg::ST_MUTE) || (flash && !blink);
   end

   assign tstart[`SMB_T_MUTE] = (next_st == smb_pkg::ST_MUTE || next_st == smb_pkg::ST_OVRD) && next_st != st;
   assign tstart[`SMB_T_BYP] = next_st == smb_pkg::ST_BYP && st != smb_pkg::ST_BYP;
   assign tstart[`SMB_T_DLY] = o_so1 && !dly && !raw && ctrl.dly_en;
   assign tstart[`SMB_T_EN] = ctrl.en_fn && rise(s.en_dev, p.en_dev);
   assign tstart[`SMB_T_SEQ] = next_st == smb_pkg::ST_ARM && st != smb_pkg::ST_ARM;
   assign trun[`SMB_T_MUTE] = st == smb_pkg::ST_MUTE || st == smb_pkg::ST_OVRD;
   assign trun[`SMB_T_BYP] = st == smb_pkg::ST_BYP;
   assign trun[`SMB_T_DLY] = dly;
   assign trun[`SMB_T_EN] = en_mode && s.en_dev;
   assign trun[`SMB_T_SEQ] = st == smb_pkg::ST_ARM;
   assign tload[`SMB_T_MUTE] = treg[`SMB_T_MUTE];
   assign tload[`SMB_T_BYP] = treg[`SMB_T_BYP];
   assign tload[`SMB_T_DLY] = treg[`SMB_T_DLY];
   assign tload[`SMB_T_EN] = treg[`SMB_T_EN];
   assign tload[`SMB_T_SEQ] = SEQ_CYCLES;

   genvar gi;
   generate
      for (gi = 0; gi < `SMB_NUM_TMR; gi++)
      begin : g_tmr
         smb_timer u_tmr
         (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .i_start(tstart[gi]),
            .i_run(trun[gi]),
            .i_load(tload[gi]),
            .o_done(tdone[gi])
         );
      end
   endgenerate

   // APB: one wait state, writes land on the completing edge
   assign acc = i_apb.psel && i_apb.penable;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_apb <= '0;
         ctrl <= `SMB_CTRL_RST;
         for (int i = 0; i < `SMB_NUM_TREG; i++)
            treg[i] <= `SMB_TIME_RST;
      end
      else
      begin
         o_apb.pready <= acc && !o_apb.pready;
         if (acc && !o_apb.pready)
         begin
            o_apb.pslverr <= !addr_ok(i_apb.paddr);
            case (i_apb.paddr)
               `SMB_A_CTRL: o_apb.prdata <= {22'h0, ctrl};
               `SMB_A_MUTE_T: o_apb.prdata <= treg[`SMB_T_MUTE];
               `SMB_A_BYP_T: o_apb.prdata <= treg[`SMB_T_BYP];
               `SMB_A_DLY_T: o_apb.prdata <= treg[`SMB_T_DLY];
               `SMB_A_EN_T: o_apb.prdata <= treg[`SMB_T_EN];
               `SMB_A_STAT: o_apb.prdata <= {18'h0, st, dir, trip, th_run, en_mode, en_lock, dly,
                                             lat_off, o_so2, o_so1};
               default: o_apb.prdata <= 32'h0;
            endcase
         end
         if (acc && o_apb.pready && i_apb.pwrite)
         begin
            case (i_apb.paddr)
               `SMB_A_CTRL: ctrl <= i_apb.pwdata[9:0];
               `SMB_A_MUTE_T: treg[`SMB_T_MUTE] <= i_apb.pwdata;
               `SMB_A_BYP_T: treg[`SMB_T_BYP] <= i_apb.pwdata;
               `SMB_A_DLY_T: treg[`SMB_T_DLY] <= i_apb.pwdata;
               `SMB_A_EN_T: treg[`SMB_T_EN] <= i_apb.pwdata;
               default: ;
            endcase
         end
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   sequence s_latched_rejoin;
      dly && ctrl.latch_en && !s.cancel && raw;
   endsequence

   sequence s_en_timeout;
      ctrl.en_fn && en_mode && s.en_dev && tdone[`SMB_T_EN];
   endsequence

   AST_MUTE_HOLDS_ON:
   assert property ((st == smb_pkg::ST_MUTE && !ctrl.two_hand && s.nm_guard && !(ctrl.en_fn && en_mode)) |-> raw)
      else $error("muted guard stop dropped the output request");
   AST_NONMUTED_STOP:
   assert property ((!s.nm_guard && !ctrl.dly_en && !(ctrl.en_fn && en_mode)) |=> !o_so1)
      else $error("non-muted stop left the output on");
   AST_MUTE_LIMIT:
   assert property ((st == smb_pkg::ST_MUTE && ctrl.lim_en && tdone[`SMB_T_MUTE]) |=> st == smb_pkg::ST_IDLE)
      else $error("mute outlived its limit");
   AST_SEQ_WINDOW:
   assert property ((st == smb_pkg::ST_ARM && tdone[`SMB_T_SEQ]) |=> st == smb_pkg::ST_IDLE)
      else $error("late second sensor still muted");
   AST_UNIDIR_REVERSE:
   assert property ((st == smb_pkg::ST_IDLE && pu_live && !ctrl.bidir && !ctrl.two_hand && rise(s.msp2, p.msp2) &&
                     !s.first_mute_sensor_pair && !rise(s.bypass, p.bypass)) |=> st == smb_pkg::ST_IDLE)
      else $error("wrong direction started a mute");
   AST_CANCEL_NOW:
   assert property ((dly && s.cancel) |=> (!o_so1 && !dly))
      else $error("cancel did not end the delay at once");
   AST_LATCH_KEEPS_DELAY:
   assert property (s_latched_rejoin |=> (dly || !o_so1))
      else $error("latched delay abandoned by returning input");
   AST_JOG_OFF:
   assert property ((!s.en_dev || !s.jog) |=> ##1 (!o_so2 || $past(s.en_dev && s.jog)))
      else $error("jog output on without both devices");
   AST_EN_TIMEOUT:
   assert property (s_en_timeout |=> !raw)
      else $error("enabling timeout did not drop the request");
   AST_BYP_EXPIRE:
   assert property ((st == smb_pkg::ST_BYP && tdone[`SMB_T_BYP]) |=> st == smb_pkg::ST_IDLE ##1 !tdone[`SMB_T_BYP])
      else $error("bypass outlived its timer");
endmodule

/* File: tb/smb_field.sv */
`timescale 1ns/1ns
module smb_field
(
   // Clock
   input wire logic i_clk,
   // Wanted device states
   input wire smb_pkg::smb_pins_t i_cmd,
   // Contacts seen by the controller
   output smb_pkg::smb_pins_t o_pins
);
   // Contacts move one edge after the operator acts, so no change lands on a request edge
   // sensors follow given order
   always_ff @(posedge i_clk)
   begin
      o_pins <= i_cmd;
   end
endmodule

/* File: tb/smb_top_tb.sv */
`timescale 1ns/1ns
`include "smb_cfg.svh"
module smb_top_tb;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   smb_pkg::smb_apb_req_t req = '0;
   smb_pkg::smb_apb_rsp_t rsp;
   // Guards in run, all else idle
   smb_pkg::smb_pins_t cmd = 13'h0180;
   smb_pkg::smb_pins_t pins;
   logic so1;
   logic so2;
   logic lamp;
   logic [31:0] rd;
   logic er;
   int bad_count = 0;
   int n_checks = 0;

   always #5 i_clk = ~i_clk;

   smb_field fld
   (
      .i_clk(i_clk),
      .i_cmd(cmd),
      .o_pins(pins)
   );

   // Short windows keep the run brief
   smb_top #(.SEQ_CYCLES(32'h14), .LAMP_CYCLES(32'h4)) uut
   (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_apb(req),
      .o_apb(rsp),
      .i_pins(pins),
      .o_so1(so1),
      .o_so2(so2),
      .o_mute_lamp(lamp)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // Outputs sampled mid-cycle, away from the updating edge
   task automatic cso(input logic e1, input logic e2);
      @(negedge i_clk);
      chk({30'h0, so2, so1}, {30'h0, e2, e1});
      @(posedge i_clk);
   endtask

   // Lamp blinks with a half period of four cycles, so samples four cycles apart differ
   task automatic clamp();
      logic a;
      @(negedge i_clk);
      a = lamp;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      chk({31'h0, a ^ lamp}, 32'h1);
      @(posedge i_clk);
   endtask

   // Request held until the edge that sees pready high; response taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_clk);
      req.penable <= 1'b1;
      do
         @(posedge i_clk);
      while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
      @(posedge i_clk);
   endtask

   task automatic t_regs();
      apb(1'b0, `SMB_A_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `SMB_A_MUTE_T, 32'h0);
      chk(rd, `SMB_TIME_RST);
      apb(1'b0, 12'hFFC, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, `SMB_A_DLY_T, 32'h14);
      apb(1'b0, `SMB_A_DLY_T, 32'h0);
      chk(rd, 32'h14);
   endtask

   task automatic t_delay();
      apb(1'b1, `SMB_A_CTRL, 32'h2);
      wt(6);
      cso(1'b1, 1'b0);
      cmd.nm_guard <= 1'b0;
      wt(6);
      cso(1'b1, 1'b0);
      wt(24);
      cso(1'b0, 1'b0);
      cmd.nm_guard <= 1'b1;
      wt(6);
      cmd.nm_guard <= 1'b0;
      wt(6);
      cmd.nm_guard <= 1'b1;
      wt(30);
      cso(1'b1, 1'b0);
      cmd.nm_guard <= 1'b0;
      wt(6);
      cmd.cancel <= 1'b1;
      wt(4);
      cso(1'b0, 1'b0);
      cmd.cancel <= 1'b0;
      cmd.nm_guard <= 1'b1;
      wt(6);
   endtask

   // One-way muting, forward then wrong order
   task automatic t_mute();
      apb(1'b1, `SMB_A_CTRL, 32'h0);
      cmd.first_mute_sensor_pair <= 1'b1;
      wt(6);
      cmd.guard <= 1'b0;
      wt(6);
      cso(1'b1, 1'b0);
      cmd.msp2 <= 1'b1;
      wt(6);
      cmd.first_mute_sensor_pair <= 1'b0;
      wt(6);
      cso(1'b1, 1'b0);
      cmd.nm_guard <= 1'b0;
      wt(6);
      cso(1'b0, 1'b0);
      cmd.msp2 <= 1'b0;
      cmd.nm_guard <= 1'b1;
      cmd.guard <= 1'b1;
      wt(6);
      cso(1'b1, 1'b0);
      cmd.msp2 <= 1'b1;
      wt(6);
      cmd.guard <= 1'b0;
      wt(6);
      cso(1'b0, 1'b0);
      cmd.first_mute_sensor_pair <= 1'b1;
      wt(6);
      cso(1'b0, 1'b0);
      cmd.first_mute_sensor_pair <= 1'b0;
      cmd.msp2 <= 1'b0;
      wt(6);
   endtask

   task automatic t_bypass();
      apb(1'b1, `SMB_A_BYP_T, 32'h28);
      wt(2);
      cso(1'b0, 1'b0);
      cmd.bypass <= 1'b1;
      wt(6);
      cso(1'b1, 1'b0);
      cmd.nm_guard <= 1'b0;
      wt(6);
      cso(1'b0, 1'b0);
      cmd.nm_guard <= 1'b1;
      wt(6);
      cso(1'b1, 1'b0);
      wt(35);
      cso(1'b0, 1'b0);
      cmd.bypass <= 1'b0;
      cmd.guard <= 1'b1;
      wt(6);
   endtask

   task automatic t_enable();
      apb(1'b1, `SMB_A_EN_T, 32'h14);
      apb(1'b1, `SMB_A_CTRL, 32'h5);
      cmd.en_dev <= 1'b1;
      cmd.jog <= 1'b1;
      wt(6);
      cso(1'b1, 1'b1);
      cmd.jog <= 1'b0;
      wt(6);
      cso(1'b1, 1'b0);
      wt(20);
      cso(1'b0, 1'b0);
      cmd.en_dev <= 1'b0;
      wt(6);
      cmd.en_dev <= 1'b1;
      wt(6);
      cso(1'b1, 1'b0);
      cmd.en_dev <= 1'b0;
      cmd.sys_btn <= 1'b1;
      wt(6);
      cmd.sys_btn <= 1'b0;
      wt(6);
      cso(1'b1, 1'b0);
   endtask

   // Two-hand with muting, mutable set released then non-mutable set
   task automatic t_two();
      apb(1'b1, `SMB_A_CTRL, 32'h200);
      wt(6);
      cso(1'b0, 1'b0);
      cmd.hand <= 1'b1;
      cmd.hand_nm <= 1'b1;
      wt(6);
      cso(1'b1, 1'b0);
      cmd.first_mute_sensor_pair <= 1'b1;
      wt(6);
      cmd.hand <= 1'b0;
      wt(6);
      cso(1'b1, 1'b0);
      cmd.hand_nm <= 1'b0;
      wt(6);
      cso(1'b0, 1'b0);
      cmd.first_mute_sensor_pair <= 1'b0;
      wt(6);
   endtask

   // Mute-dependent override started by bypass, ended by sensors clearing
   task automatic t_ovrd();
      apb(1'b1, `SMB_A_CTRL, 32'h10);
      cmd.guard <= 1'b0;
      wt(6);
      cso(1'b0, 1'b0);
      cmd.first_mute_sensor_pair <= 1'b1;
      wt(6);
      clamp();
      cmd.bypass <= 1'b1;
      wt(6);
      cso(1'b1, 1'b0);
      clamp();
      cmd.first_mute_sensor_pair <= 1'b0;
      wt(6);
      cso(1'b0, 1'b0);
      cmd.bypass <= 1'b0;
      cmd.guard <= 1'b1;
      wt(6);
      cso(1'b1, 1'b0);
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial
   begin
      wt(2);
      i_sys_rst <= 1'b0;
      wt(4);
      t_regs();
      t_delay();
      t_mute();
      t_bypass();
      t_enable();
      t_two();
      t_ovrd();
      end_sim();
   end

   // Whole run is well under a thousand cycles
   initial
   begin
      #100000;
      bad_count++;
      end_sim();
   end
endmodule
